// File: hdl/lscu_top.sv
// file: link state machine slice for compliance, u0 and u1 entry
`timescale 1ns/100ps
module lscu_top
  import lscu_pkg::*;
#(
  parameter int RXGAP_N = RXGAP_CYC,
  parameter int TXIDLE_N = TXIDLE_CYC,
  parameter int PING_N = PING_CYC,
  parameter int PORTCFG_N = PORTCFG_CYC,
  parameter logic [PAT_W-1:0] PAT_LAST = PAT_LAST_DEF
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic DOWNSTREAM,
  input wire lscu_pkg::lscu_rx_t RX_EV,
  input wire lscu_pkg::lscu_dir_t DIR_EV,
  input wire logic TX_BUSY,
  input wire logic U2_EXPIRED,
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  output lscu_pkg::lscu_state_t LINK_STATE,
  output logic [PAT_W-1:0] PATTERN,
  output lscu_pkg::lscu_tx_t TX_REQ,
  output logic U2_TMR_RUN,
  output logic [U2T_W-1:0] U2_TIMEOUT
);
  localparam int TW = 25;
  localparam int HPR_SLACK = 3;
  localparam int HPR_MAX_K = HPR_G1X1_CYC - 1;

  lscu_state_t st, next_st;
  logic [PAT_W-1:0] pat, next_pat;
  logic [2:0] u3_fails, next_u3_fails;
  logic [2:0] php_cnt, next_php_cnt;
  logic cfg_done, next_cfg_done;
  logic u2_run, next_u2_run;
  lscu_tx_t tx, next_tx;
  logic hp_pend, next_hp_pend;
  logic lgo_pend, next_lgo_pend;
  logic [HPR_W-1:0] hp_age, next_hp_age;
  logic [HPR_W-1:0] hp_lim;
  logic [31:0] ctrl, u2t, stat, wb_dat;
  logic wb_ack;
  logic in_u0, in_u1, gap_exp, idle_exp, ping_exp, cfg_exp;
  logic idle_run, u1_entry;

  lscu_wb u_wb (
    .clk(CLOCK),
    .rst_n(RST_N),
    .cyc(WB_CYC),
    .stb(WB_STB),
    .we(WB_WE),
    .adr(WB_ADR),
    .sel(WB_SEL),
    .dat_w(WB_DAT_I),
    .stat(stat),
    .dat_r(wb_dat),
    .ack(wb_ack),
    .ctrl(ctrl),
    .u2t(u2t)
  );

  // status: state, pattern, failure counters, config flag
  assign stat = {16'h0000, 1'h0, cfg_done, php_cnt, u3_fails, pat, st};

  assign in_u0 = (st == LS_U0);
  assign in_u1 = (st == LS_U1);
  assign u1_entry = (next_st == LS_U1) && !in_u1;
  // counts only while the transmitter is in logical idle
  assign idle_run = in_u0 && !TX_BUSY;

  // gap restarts on a link command; upstream also on packets
  lscu_tmr #(.W(TW)) u_gap (
    .clk(CLOCK),
    .rst_n(RST_N),
    .run(in_u0),
    .restart(RX_EV.lcmd || (!DOWNSTREAM && RX_EV.pkt)),
    .load(TW'(RXGAP_N)),
    .expired(gap_exp)
  );

  lscu_tmr #(.W(TW)) u_idle (
    .clk(CLOCK),
    .rst_n(RST_N),
    .run(idle_run),
    .restart(1'b0),
    .load(TW'(TXIDLE_N)),
    .expired(idle_exp)
  );

  // restarted on every ping from the configuration lane
  lscu_tmr #(.W(TW)) u_ping (
    .clk(CLOCK),
    .rst_n(RST_N),
    .run(in_u1 && DOWNSTREAM),
    .restart(RX_EV.ping_cfg),
    .load(TW'(PING_N)),
    .expired(ping_exp)
  );

  lscu_tmr #(.W(TW)) u_cfg (
    .clk(CLOCK),
    .rst_n(RST_N),
    .run(in_u0 && !cfg_done),
    .restart(1'b0),
    .load(TW'(PORTCFG_N)),
    .expired(cfg_exp)
  );

  // pend flop, output flop and a strict limit cost three budget cycles
  always_comb begin
    unique case ({ctrl[CTRL_X2], ctrl[CTRL_GEN2]})
      2'b00: hp_lim = HPR_W'(HPR_G1X1_CYC - HPR_SLACK);
      2'b01: hp_lim = HPR_W'(HPR_G2X1_CYC - HPR_SLACK);
      2'b10: hp_lim = HPR_W'(HPR_G1X2_CYC - HPR_SLACK);
      2'b11: hp_lim = HPR_W'(HPR_G2X2_CYC - HPR_SLACK);
    endcase
  end

  always_comb begin
    next_st = st;
    next_pat = pat;
    next_u3_fails = u3_fails;
    next_php_cnt = php_cnt;
    next_cfg_done = cfg_done;
    unique case (st)
      LS_IDLE, LS_RXDET, LS_RECOV, LS_INACT, LS_DISAB: begin
        // compliance entry for downstream only when enabled
        if (DIR_EV.to_compl && (!DOWNSTREAM || ctrl[CTRL_CMPEN])) begin
          next_st = LS_COMPL;
          next_pat = PAT_FIRST;
        end else if (DIR_EV.to_u0) begin
          next_st = LS_U0;
        end
      end
      LS_COMPL: begin
        if (DOWNSTREAM ? DIR_EV.warm : RX_EV.warm_det) begin
          next_st = LS_RXDET;
        end else if (DOWNSTREAM && DIR_EV.disab) begin
          next_st = LS_DISAB;
        end else if (RX_EV.ping_cfg) begin
          // wrap after the final pattern
          next_pat = (pat == PAT_LAST) ? PAT_FIRST : pat + PAT_ONE;
        end
      end
      LS_U0: begin
        if (RX_EV.php_to) begin
          next_php_cnt = php_cnt + CNT3_ONE;
        end else if (DIR_EV.php_clr) begin
          next_php_cnt = CNT3_ZERO;
        end
        if (RX_EV.pcap) begin
          next_cfg_done = 1'b1;
        end
        if (DIR_EV.u3_done) begin
          next_u3_fails = CNT3_ZERO;
        end else if (DIR_EV.u3_fail) begin
          next_u3_fails = u3_fails + CNT3_ONE;
        end
        if (DOWNSTREAM ? DIR_EV.warm : RX_EV.warm_det) begin
          next_st = LS_RXDET;
        end else if (DIR_EV.disab) begin
          next_st = LS_DISAB;
        end else if (DOWNSTREAM && DIR_EV.inact) begin
          next_st = LS_INACT;
        end else if (cfg_exp) begin
          next_st = DOWNSTREAM ? LS_INACT : LS_DISAB;
        end else if (RX_EV.php_to
                     && php_cnt == 3'(PHP_TO_MAX - 1)) begin
          next_st = LS_INACT;
        end else if (DOWNSTREAM && DIR_EV.u3_fail
                     && u3_fails == 3'(U3_FAIL_MAX - 1)) begin
          next_st = LS_INACT;
        end else if (RX_EV.php_to || RX_EV.ts1 || RX_EV.link_err
                     || DIR_EV.recov || gap_exp) begin
          // gap expiry covers both port roles
          next_st = LS_RECOV;
        end else if (DIR_EV.u1_done) begin
          next_st = LS_U1;
        end else if (DIR_EV.u2_done) begin
          next_st = LS_U2;
        end else if (DIR_EV.u3_done) begin
          next_st = LS_U3;
        end
      end
      LS_U1: begin
        if (DOWNSTREAM && DIR_EV.disab) begin
          next_st = LS_DISAB;
        end else if (DOWNSTREAM ? (DIR_EV.warm || ping_exp)
                                : RX_EV.warm_det) begin
          next_st = LS_RXDET;
        end else if (U2_EXPIRED && u2_run) begin
          next_st = LS_U2;
        end else if (DIR_EV.recov) begin
          next_st = LS_RECOV;
        end
      end
      LS_U2, LS_U3: begin
        if (DIR_EV.disab) begin
          next_st = LS_DISAB;
        end else if (DIR_EV.warm || RX_EV.warm_det) begin
          next_st = LS_RXDET;
        end else if (DIR_EV.recov) begin
          next_st = LS_RECOV;
        end
      end
    endcase
    if (next_st == LS_RXDET || next_st == LS_DISAB
        || next_st == LS_INACT) begin
      next_cfg_done = 1'b0;
      next_php_cnt = CNT3_ZERO;
    end
  end

  // u2 inactivity timer starts on u1 entry if timeout nonzero
  always_comb begin
    next_u2_run = u2_run;
    if (u1_entry) begin
      next_u2_run = (u2t[U2T_W-1:0] != U2T_ZERO);
    end else if (next_st != LS_U1) begin
      next_u2_run = 1'b0;
    end
  end

  // one keep-alive per expiry; header answers within budget, lgo ones too unless queued behind a header answer
  always_comb begin
    next_tx = '0;
    next_hp_pend = hp_pend;
    next_lgo_pend = lgo_pend;
    next_hp_age = hp_age;
    if (idle_exp) begin
      next_tx.ldn = DOWNSTREAM;
      next_tx.lup = !DOWNSTREAM;
    end
    if (RX_EV.hp && in_u0) begin
      next_hp_pend = 1'b1;
    end
    if (RX_EV.lgo && in_u0) begin
      next_lgo_pend = 1'b1;
    end
    if (hp_pend || lgo_pend) begin
      next_hp_age = hp_age + HPR_ONE;
    end
    // answer as soon as the transmitter is free or budget runs out
    if (hp_pend && (!TX_BUSY || hp_age >= hp_lim)) begin
      next_tx.lgood = 1'b1;
      next_hp_pend = RX_EV.hp && in_u0;
      next_hp_age = HPR_ZERO;
    end else if (lgo_pend && (!TX_BUSY || hp_age >= hp_lim)) begin
      next_tx.lau = 1'b1;
      next_lgo_pend = RX_EV.lgo && in_u0;
      next_hp_age = HPR_ZERO;
    end
    if (!in_u0) begin
      next_hp_pend = 1'b0;
      next_lgo_pend = 1'b0;
      next_hp_age = HPR_ZERO;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st <= LS_IDLE;
      pat <= PAT_FIRST;
      u3_fails <= CNT3_ZERO;
      php_cnt <= CNT3_ZERO;
      cfg_done <= 1'b0;
      u2_run <= 1'b0;
      tx <= '0;
      hp_pend <= 1'b0;
      lgo_pend <= 1'b0;
      hp_age <= HPR_ZERO;
      LINK_STATE <= LS_IDLE;
      PATTERN <= PAT_FIRST;
      TX_REQ <= '0;
      U2_TMR_RUN <= 1'b0;
      U2_TIMEOUT <= U2T_ZERO;
      WB_DAT_O <= RD_ZERO;
      WB_ACK <= 1'b0;
    end else begin
      st <= next_st;
      pat <= next_pat;
      u3_fails <= next_u3_fails;
      php_cnt <= next_php_cnt;
      cfg_done <= next_cfg_done;
      u2_run <= next_u2_run;
      tx <= next_tx;
      hp_pend <= next_hp_pend;
      lgo_pend <= next_lgo_pend;
      hp_age <= next_hp_age;
      LINK_STATE <= next_st;
      PATTERN <= next_pat;
      TX_REQ <= next_tx;
      U2_TMR_RUN <= next_u2_run;
      U2_TIMEOUT <= u2t[U2T_W-1:0];
      WB_DAT_O <= wb_dat;
      WB_ACK <= wb_ack;
    end
  end

  chk_compl_gate: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st != LS_COMPL && DOWNSTREAM && !ctrl[CTRL_CMPEN]
    |=> st != LS_COMPL)
    else $error("compliance entered while disabled");

  chk_pat_step: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st == LS_COMPL && next_st == LS_COMPL && RX_EV.ping_cfg
    && pat != PAT_LAST |=> pat == $past(pat) + PAT_ONE)
    else $error("pattern did not advance");

  chk_pat_wrap: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st == LS_COMPL && next_st == LS_COMPL && RX_EV.ping_cfg
    && pat == PAT_LAST |=> pat == PAT_FIRST)
    else $error("pattern did not wrap");

  chk_warm_exit: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st == LS_COMPL && !DOWNSTREAM && RX_EV.warm_det
    |=> st == LS_RXDET)
    else $error("warm reset not honoured");

  sequence s_keepalive;
    idle_exp ##1 (TX_REQ.ldn == DOWNSTREAM && TX_REQ.lup == !DOWNSTREAM);
  endsequence
  chk_keep_alive: assert property (@(posedge CLOCK) disable iff (!RST_N)
    idle_exp |-> s_keepalive)
    else $error("keep-alive not sent");

  chk_hp_answer: assert property (@(posedge CLOCK) disable iff (!RST_N)
    in_u0 && RX_EV.hp && !hp_pend && !lgo_pend
    |-> ##[1:HPR_MAX_K] (tx.lgood || !in_u0))
    else $error("header packet unanswered");

  chk_php_inact: assert property (@(posedge CLOCK) disable iff (!RST_N)
    in_u0 && RX_EV.php_to && php_cnt == 3'(PHP_TO_MAX - 1) && !DIR_EV.warm
    && !RX_EV.warm_det && !DIR_EV.disab && !DIR_EV.inact && !cfg_exp
    |=> st == LS_INACT)
    else $error("fourth timeout not inactive");

  chk_u2_start: assert property (@(posedge CLOCK) disable iff (!RST_N)
    $rose(in_u1) |-> u2_run == (u2t[U2T_W-1:0] != U2T_ZERO))
    else $error("u2 timer start wrong");

  chk_gap_recov: assert property (@(posedge CLOCK) disable iff (!RST_N)
    in_u0 && gap_exp && next_st != LS_RXDET && next_st != LS_DISAB
    && next_st != LS_INACT |=> st == LS_RECOV)
    else $error("gap timeout missed");
endmodule : lscu_top

// File: pkg/lscu_pkg.sv
// package: states, timing constants, wishbone map and carriers for link fsm
package lscu_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  // times in their own unit, counts derived from the clock rate
  localparam int T_RXGAP_MS = 1;
  localparam int T_TXIDLE_US = 10;
  localparam int T_PING_MS = 300;
  localparam int T_PORTCFG_US = 20;
  localparam int RXGAP_CYC = T_RXGAP_MS * (CLK_HZ / 1000);
  localparam int TXIDLE_CYC = T_TXIDLE_US * (CLK_HZ / 1000000);
  localparam int PING_CYC = T_PING_MS * (CLK_HZ / 1000);
  localparam int PORTCFG_CYC = T_PORTCFG_US * (CLK_HZ / 1000000);
  // header response limits in ns, least cycles rounded down
  localparam int HPR_G1X1_NS = 2540;
  localparam int HPR_G2X1_NS = 1610;
  localparam int HPR_G1X2_NS = 2270;
  localparam int HPR_G2X2_NS = 1355;
  localparam int HPR_G1X1_CYC = HPR_G1X1_NS / CLK_NS;
  localparam int HPR_G2X1_CYC = HPR_G2X1_NS / CLK_NS;
  localparam int HPR_G1X2_CYC = HPR_G1X2_NS / CLK_NS;
  localparam int HPR_G2X2_CYC = HPR_G2X2_NS / CLK_NS;
  localparam int HPR_W = 8;
  localparam logic [HPR_W-1:0] HPR_ZERO = 8'h00;
  localparam logic [HPR_W-1:0] HPR_ONE = 8'h01;
  localparam int U3_FAIL_MAX = 3;
  localparam int PHP_TO_MAX = 4;
  localparam logic [2:0] CNT3_ZERO = 3'h0;
  localparam logic [2:0] CNT3_ONE = 3'h1;
  localparam int PAT_W = 4;
  localparam logic [PAT_W-1:0] PAT_FIRST = 4'h0;
  localparam logic [PAT_W-1:0] PAT_ONE = 4'h1;
  localparam logic [PAT_W-1:0] PAT_LAST_DEF = 4'hF;
  localparam int U2T_W = 16;
  localparam logic [U2T_W-1:0] U2T_ZERO = 16'h0000;
  // wishbone register map, byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_U2T = 8'h08;
  localparam int CTRL_CMPEN = 0;
  localparam int CTRL_GEN2 = 1;
  localparam int CTRL_X2 = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] U2T_RST = 32'h0000_0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    LS_IDLE, LS_COMPL, LS_U0, LS_U1, LS_U2, LS_U3,
    LS_RXDET, LS_RECOV, LS_INACT, LS_DISAB
  } lscu_state_t;

  // rx events, one-cycle pulses from the link layer
  typedef struct packed {
    logic lcmd;
    logic pkt;
    logic hp;
    logic lgo;
    logic ts1;
    logic ping_cfg;
    logic warm_det;
    logic link_err;
    logic php_to;
    logic pcap;
  } lscu_rx_t;

  // directed commands and handshake results, pulses
  typedef struct packed {
    logic to_compl;
    logic to_u0;
    logic recov;
    logic disab;
    logic inact;
    logic warm;
    logic u1_done;
    logic u2_done;
    logic u3_done;
    logic u3_fail;
    logic php_clr;
  } lscu_dir_t;

  typedef struct packed {
    logic ldn;
    logic lup;
    logic lgood;
    logic lau;
  } lscu_tx_t;
endpackage : lscu_pkg

// File: hdl/lscu_tmr.sv
// file: restartable down-counting timer with expiry pulse
`timescale 1ns/100ps
module lscu_tmr #(
  parameter int W = 25
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic restart,
  input wire logic [W-1:0] load,
  output logic expired
);
  logic [W-1:0] cnt, next_cnt;
  logic next_expired;
  logic zero;

  assign zero = (cnt == '0);

  always_comb begin
    next_cnt = cnt;
    next_expired = 1'b0;
    if (restart || !run) begin
      next_cnt = load;
    end else if (!zero) begin
      next_cnt = cnt - 1'b1;
      next_expired = (cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '0;
      expired <= 1'b0;
    end else begin
      cnt <= next_cnt;
      expired <= next_expired;
    end
  end
endmodule : lscu_tmr

// File: hdl/lscu_wb.sv
// file: wishbone classic slave holding control and u2 timeout registers
`timescale 1ns/100ps
module lscu_wb
  import lscu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [3:0] sel,
  input wire logic [31:0] dat_w,
  input wire logic [31:0] stat,
  output logic [31:0] dat_r,
  output logic ack,
  output logic [31:0] ctrl,
  output logic [31:0] u2t
);
  logic [31:0] next_ctrl, next_u2t, next_dat_r;
  logic next_ack, ack_d, next_ack_d;
  logic take;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // the top registers ack once more; blocking two cycles keeps a master
  // that holds its request until that ack from being taken twice
  assign take = cyc && stb && !ack && !ack_d;

  always_comb begin
    next_ctrl = ctrl;
    next_u2t = u2t;
    next_dat_r = RD_ZERO;
    next_ack = take;
    next_ack_d = ack;
    if (take && we) begin
      if (adr == ADR_CTRL) next_ctrl = merge(ctrl, dat_w, sel);
      if (adr == ADR_U2T) next_u2t = merge(u2t, dat_w, sel);
    end else if (take) begin
      unique case (adr)
        ADR_CTRL: next_dat_r = ctrl;
        ADR_STAT: next_dat_r = stat;
        ADR_U2T: next_dat_r = u2t;
        default: next_dat_r = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      u2t <= U2T_RST;
      dat_r <= RD_ZERO;
      ack <= 1'b0;
      ack_d <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      u2t <= next_u2t;
      dat_r <= next_dat_r;
      ack <= next_ack;
      ack_d <= next_ack_d;
    end
  end
endmodule : lscu_wb

// File: verif/lscu_partner.sv
// far-end port model: periodic link commands, pings and requested events
`timescale 1ns/100ps
module lscu_partner
  import lscu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lcmd_on,
  input wire logic ping_on,
  input wire lscu_pkg::lscu_rx_t req,
  output lscu_pkg::lscu_rx_t rx
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  always_comb begin
    next_cnt = cnt + 6'h01;
    rx = req;
    // a link command every 16 cycles keeps well inside the receive gap
    rx.lcmd = req.lcmd | (lcmd_on & (cnt[3:0] == 4'hF));
    rx.ping_cfg = req.ping_cfg | (ping_on & (cnt == 6'h3F));
  end
  always_ff @(posedge clk) begin
    cnt <= rst_n ? next_cnt : 6'h00;
  end
endmodule : lscu_partner

// File: verif/test_lscu_top.sv
// self-checking bench for the compliance, u0 and u1 link state slice
`timescale 1ns/100ps
module test_lscu_top;
  import lscu_pkg::*;
  // short timers keep the run small; expectations use the same values
  localparam int RXG = 50;
  localparam int TXI = 20;
  localparam int PNG = 100;
  localparam logic [PAT_W-1:0] PLAST = 4'h3;
  localparam lscu_dir_t D_U0 = '{to_u0: 1'b1, default: 1'b0};
  localparam lscu_dir_t D_CMP = '{to_compl: 1'b1, default: 1'b0};
  localparam lscu_dir_t D_U1 = '{u1_done: 1'b1, default: 1'b0};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ds = 1'b1;
  logic tx_busy = 1'b0;
  logic lcmd_on = 1'b0;
  logic ping_on = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack;
  lscu_rx_t rq = '0;
  lscu_rx_t rx;
  lscu_dir_t dir = '0;
  lscu_state_t st;
  logic [PAT_W-1:0] pat;
  lscu_tx_t tx;
  logic u2_run;
  logic [U2T_W-1:0] u2_to;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;
  logic [31:0] q;
  always #10 clock = ~clock;
  lscu_partner i_far (.clk(clock), .rst_n(rst_n), .lcmd_on(lcmd_on),
    .ping_on(ping_on), .req(rq), .rx(rx));
  lscu_top #(.RXGAP_N(RXG), .TXIDLE_N(TXI), .PING_N(PNG), .PORTCFG_N(80),
    .PAT_LAST(PLAST)) i_dut (.CLOCK(clock), .RST_N(rst_n), .DOWNSTREAM(ds),
    .RX_EV(rx), .DIR_EV(dir), .TX_BUSY(tx_busy), .U2_EXPIRED(1'b0),
    .WB_CYC(wb_cyc), .WB_STB(wb_stb), .WB_WE(wb_we), .WB_ADR(wb_adr),
    .WB_SEL(4'hF), .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o),
    .WB_ACK(wb_ack), .LINK_STATE(st), .PATTERN(pat), .TX_REQ(tx),
    .U2_TMR_RUN(u2_run), .U2_TIMEOUT(u2_to));
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic ev(input lscu_dir_t d, input lscu_rx_t r);
    @(posedge clock);
    dir <= d;
    rq <= r;
    @(posedge clock);
    dir <= '0;
    rq <= '0;
  endtask : ev
  task automatic tk(input int c);
    repeat (c) @(negedge clock);
  endtask : tk
  task automatic wait_st(input lscu_state_t e, input int lim);
    n = 0;
    while (st !== e && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk("link_state", 32'(e), 32'(st));
    if (st !== e) final_report();
  endtask : wait_st
  task automatic wait_tx(input int b, input int lim);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (tx[b] !== 1'b1 && n < lim);
    chk("tx_req", 32'h1, {31'h0, tx[b]});
    if (tx[b] !== 1'b1) final_report();
  endtask : wait_tx
  // request held until ack is sampled high at a rising edge, then released
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk("wb_ack", 32'h1, {31'h0, wb_ack});
    if (wb_ack !== 1'b1) final_report();
  endtask : wb
  task automatic rst(input logic d, input int c);
    @(posedge clock);
    rst_n <= 1'b0;
    ds <= d;
    lcmd_on <= 1'b0;
    ping_on <= 1'b0;
    tx_busy <= 1'b0;
    repeat (c) @(posedge clock);
    rst_n <= 1'b1;
  endtask : rst
  task automatic go_u0(input logic d);
    rst(d, 2);
    ev(D_U0, '0);
    wait_st(LS_U0, 6);
    ev('0, '{pcap: 1'b1, default: 1'b0});
  endtask : go_u0
  task automatic t_regs;
    wb(1'b0, ADR_CTRL, 32'h0000_0000);
    chk("ctrl", CTRL_RST, q);
    wb(1'b0, ADR_U2T, 32'h0000_0000);
    chk("u2t", U2T_RST, q);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", RD_ZERO, q);
    wb(1'b1, ADR_U2T, 32'h0000_0005);
    wb(1'b0, ADR_U2T, 32'h0000_0000);
    chk("u2t", 32'h0000_0005, q);
    chk("u2_timeout", 32'h0000_0005, {16'h0000, u2_to});
    $display("test regs done");
  endtask : t_regs
  task automatic t_compl;
    rst(1'b1, 2);
    ev(D_CMP, '0);
    tk(4);
    chk("compl_blocked", 32'h0, {31'h0, st === LS_COMPL});
    wb(1'b1, ADR_CTRL, 32'h0000_0001);
    ev(D_CMP, '0);
    wait_st(LS_COMPL, 6);
    chk("pattern", 32'(PAT_FIRST), 32'(pat));
    for (int i = 1; i <= 5; i++) begin
      ev('0, '{ping_cfg: 1'b1, default: 1'b0});
      tk(3);
      chk("pattern", 32'(i % (PLAST + 1)), 32'(pat));
    end
    ev('{warm: 1'b1, default: 1'b0}, '0);
    wait_st(LS_RXDET, 6);
    ev(D_CMP, '0);
    wait_st(LS_COMPL, 6);
    ev('{disab: 1'b1, default: 1'b0}, '0);
    wait_st(LS_DISAB, 6);
    rst(1'b0, 2);
    ev(D_CMP, '0);
    wait_st(LS_COMPL, 6);
    ev('0, '{warm_det: 1'b1, default: 1'b0});
    wait_st(LS_RXDET, 6);
    $display("test compliance done");
  endtask : t_compl
  task automatic t_exits;
    lscu_dir_t d;
    lscu_rx_t r;
    lscu_state_t e;
    for (int i = 0; i < 8; i++) begin
      go_u0(1'b1);
      d = '0;
      r = '0;
      e = LS_RECOV;
      case (i)
        0: d.recov = 1'b1;
        1: r.ts1 = 1'b1;
        2: r.link_err = 1'b1;
        3: begin d.u1_done = 1'b1; e = LS_U1; end
        4: begin d.u2_done = 1'b1; e = LS_U2; end
        5: begin d.u3_done = 1'b1; e = LS_U3; end
        6: begin d.disab = 1'b1; e = LS_DISAB; end
        default: begin d.inact = 1'b1; e = LS_INACT; end
      endcase
      ev(d, r);
      wait_st(e, 6);
    end
    $display("test u0 exits done");
  endtask : t_exits
  task automatic t_counts;
    go_u0(1'b1);
    lcmd_on <= 1'b1;
    for (int i = 1; i <= 3; i++) begin
      chk("u3_fail_state", 32'(LS_U0), 32'(st));
      ev('{u3_fail: 1'b1, default: 1'b0}, '0);
      tk(3);
    end
    wait_st(LS_INACT, 4);
    go_u0(1'b1);
    lcmd_on <= 1'b1;
    for (int i = 1; i <= 4; i++) begin
      chk("php_state", 32'h0, {31'h0, st === LS_INACT});
      if (i > 1) ev(D_U0, '0);
      tk(3);
      ev('0, '{php_to: 1'b1, default: 1'b0});
      tk(3);
    end
    wait_st(LS_INACT, 4);
    // no capability packet: config timer ends u0 for either role
    for (int k = 0; k < 2; k++) begin
      rst(k[0], 2);
      lcmd_on <= 1'b1;
      ev(D_U0, '0);
      wait_st(k[0] ? LS_INACT : LS_DISAB, 90);
    end
    $display("test counts done");
  endtask : t_counts
  task automatic t_gap;
    go_u0(1'b1);
    wait_st(LS_RECOV, RXG + 10);
    chk("gap_length", 32'h1, {31'h0, n >= RXG - 5});
    go_u0(1'b1);
    lcmd_on <= 1'b1;
    tk(3 * RXG);
    chk("gap_fed", 32'(LS_U0), 32'(st));
    go_u0(1'b0);
    for (int i = 0; i < 6; i++) begin
      ev('0, '{pkt: 1'b1, default: 1'b0});
      tk(RXG / 2);
    end
    chk("gap_pkt", 32'(LS_U0), 32'(st));
    wait_st(LS_RECOV, RXG + 10);
    $display("test receive gap done");
  endtask : t_gap
  task automatic t_idle;
    int p;
    for (int k = 0; k < 2; k++) begin
      go_u0(k[0]);
      lcmd_on <= 1'b1;
      tx_busy <= 1'b1;
      p = 0;
      repeat (2 * TXI) begin
        @(negedge clock);
        p += int'(tx.ldn | tx.lup);
      end
      chk("idle_busy", 32'h0, 32'(p));
      @(posedge clock);
      tx_busy <= 1'b0;
      wait_tx(2 + k, 3 * TXI);
      chk("idle_len", 32'h1, {31'h0, n >= TXI - 2 && n <= TXI + 3});
      chk("idle_kind", {30'h0, k[0], ~k[0]}, {30'h0, tx.ldn, tx.lup});
      p = 0;
      repeat (TXI - 4) begin
        @(negedge clock);
        p += int'(tx.ldn | tx.lup);
      end
      chk("idle_once", 32'h0, 32'(p));
    end
    $display("test transmit idle done");
  endtask : t_idle
  task automatic t_resp;
    int l [4];
    l = '{HPR_G1X1_NS, HPR_G2X1_NS, HPR_G1X2_NS, HPR_G2X2_NS};
    go_u0(1'b1);
    lcmd_on <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wb(1'b1, ADR_CTRL, 32'(c << 1));
      @(posedge clock);
      tx_busy <= 1'b1;
      ev('0, '{hp: 1'b1, default: 1'b0});
      wait_tx(1, l[c] / CLK_NS + 2);
      // edges from the sampled event to the answer, in ns
      n = (n - 1) * CLK_NS;
      chk("hp_time", 32'h1, {31'h0, n < l[c]});
      ev('0, '{lgo: 1'b1, default: 1'b0});
      wait_tx(0, l[c] / CLK_NS + 2);
      n = (n - 1) * CLK_NS;
      chk("lgo_time", 32'h1, {31'h0, n < l[c]});
      @(posedge clock);
      tx_busy <= 1'b0;
    end
    $display("test response time done");
  endtask : t_resp
  task automatic t_u1;
    go_u0(1'b1);
    lcmd_on <= 1'b1;
    wb(1'b1, ADR_U2T, 32'h0000_0007);
    ping_on <= 1'b1;
    ev(D_U1, '0);
    wait_st(LS_U1, 6);
    chk("u2_run", 32'h1, {31'h0, u2_run});
    tk(3 * PNG);
    chk("u1_pinged", 32'(LS_U1), 32'(st));
    @(posedge clock);
    ping_on <= 1'b0;
    wait_st(LS_RXDET, PNG + 70);
    go_u0(1'b1);
    ev(D_U1, '0);
    wait_st(LS_U1, 6);
    chk("u2_run", 32'h0, {31'h0, u2_run});
    $display("test u1 entry done");
  endtask : t_u1
  initial begin
    rst(1'b1, 10);
    t_regs();
    t_compl();
    t_exits();
    t_counts();
    t_gap();
    t_idle();
    t_resp();
    t_u1();
    final_report();
  end
endmodule : test_lscu_top
